// File: evl_defines.svh
`ifndef EVL_DEFINES_SVH
`define EVL_DEFINES_SVH

// Register byte offsets.
`define EVL_REG_GATE_BASE 8'h00
`define EVL_REG_TC_BASE 8'h18
`define EVL_REG_DI_LOOP 8'h20
`define EVL_REG_DI_FUNC 8'h24
`define EVL_REG_STATUS 8'h28

// Gate configuration field positions.
`define EVL_GATE_FUNC_LSB 0
`define EVL_GATE_SRC1_LSB 2
`define EVL_GATE_SRC2_LSB 7
`define EVL_GATE_COND1_LSB 12
`define EVL_GATE_COND2_LSB 14
`define EVL_GATE_SENSE_BIT 16

// Timer/counter configuration field positions.
`define EVL_TC_PRESET_LSB 0
`define EVL_TC_SRC_LSB 13
`define EVL_TC_MODE_BIT 18
`define EVL_TC_SENSE_BIT 19

// Contact input configuration and status register field positions.
`define EVL_DI_LOOP_W 2
`define EVL_DI_LEVEL_BIT 20
`define EVL_DI_FUNC_W 3
`define EVL_STAT_RUN_LSB 10
`define EVL_STAT_OUT_LSB 12

// Reset values.
`define EVL_GATE_RESET 17'h00000
`define EVL_TC_RESET 20'h00000
`define EVL_DI_LOOP_RESET 2'h0

// Source selector codes.
`define EVL_SRC_TS1_FIRST 5'h01
`define EVL_SRC_TS2_LAST 5'h10
`define EVL_SRC_LAST 5'h1A

// Limits and timing.
`define EVL_PRESET_MAX 13'h1388
`define EVL_CLK_HZ 20000000
`define EVL_PULSE_SEC 1
`define EVL_STABLE_MS 100

`endif

// File: evl_pkg.sv
package evl_pkg;
  typedef enum logic [1:0] {FUNC_AND, FUNC_OR, FUNC_XOR} logic_func_type;
  typedef enum logic [1:0] {COND_PASS, COND_NEGATE, COND_TOGGLE} cond_type;
  typedef enum logic {TC_TIMER, TC_COUNTER} tc_mode_type;
  typedef enum logic [1:0] {LOOP_ONE, LOOP_TWO, LOOP_BOTH} loop_assign_type;
  typedef enum logic [2:0] {
    DI_NONE, DI_RUN_RESET, DI_OTHER, DI_PAT_TWO, DI_PAT_THREE, DI_PAT_FOUR, DI_PAT_FIVE
  } di_func_type;
  typedef logic [4:0] src_sel_type;

  typedef struct packed {
    logic sense;
    cond_type cond2;
    cond_type cond1;
    src_sel_type src2;
    src_sel_type src1;
    logic_func_type func;
  } gate_cfg_type;

  typedef struct packed {
    logic sense;
    tc_mode_type mode;
    src_sel_type src;
    logic [12:0] preset;
  } tc_cfg_type;
endpackage

// File: contact_filter.sv
module contact_filter #(
  parameter int unsigned STABLE_CYCLES = 2000000
) (
  input wire logic core_clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic raw_i, // Raw contact level.
  output logic level_o, // Filtered level.
  output logic rise_o // One-cycle pulse on filtered rise.
);
  logic sync_a;
  logic sync_b;
  logic [21:0] stable_cnt;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
    end
  end

  // A new level is taken only after it has stood unchanged for the whole window.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stable_cnt <= 22'h000000;
      level_o <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      if (sync_b == level_o) begin
        stable_cnt <= 22'h000000;
      end else if (stable_cnt == 22'(STABLE_CYCLES - 1)) begin
        stable_cnt <= 22'h000000;
        level_o <= sync_b;
        rise_o <= sync_b;
      end else begin
        stable_cnt <= stable_cnt + 22'h000001;
      end
    end
  end
endmodule // contact_filter

// File: gate_input.sv
`include "evl_defines.svh"

module gate_input
  import evl_pkg::*;
(
  input wire logic core_clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset.
  input evl_pkg::src_sel_type sel_i, // Selected source code.
  input evl_pkg::cond_type cond_i, // Conditioning mode.
  input wire logic [26:0] level_i, // Source levels by code.
  input wire logic [26:0] rise_i, // Source rise pulses by code.
  output logic cond_o // Conditioned signal.
);
  logic lvl;
  logic rise;
  logic latch;

  always_comb begin
    lvl = 1'b0;
    rise = 1'b0;
    if (sel_i <= `EVL_SRC_LAST) begin
      lvl = level_i[sel_i];
      rise = rise_i[sel_i];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      latch <= 1'b0;
    end else if (cond_i == COND_TOGGLE && rise) begin
      latch <= ~latch;
    end
  end

  always_comb begin
    unique case (cond_i)
      COND_PASS: cond_o = lvl;
      COND_NEGATE: cond_o = ~lvl;
      COND_TOGGLE: cond_o = latch;
      default: cond_o = lvl;
    endcase
  end
endmodule // gate_input

// File: event_logic_timer_counter.sv
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`include "evl_defines.svh"

module event_logic_timer_counter #(
  parameter int unsigned ONE_SEC_CYCLES = `EVL_CLK_HZ * `EVL_PULSE_SEC,
  parameter int unsigned STABLE_CYCLES = `EVL_CLK_HZ / 1000 * `EVL_STABLE_MS
) (
  input wire logic core_clk_i, // 20 MHz system clock.
  input wire logic rst_i, // Synchronous active-high reset.
  input wire logic hsel_i, // AHB slave select.
  input wire logic [31:0] haddr_i, // AHB address.
  input wire logic [1:0] htrans_i, // AHB transfer type.
  input wire logic hwrite_i, // AHB write flag.
  input wire logic [2:0] hsize_i, // AHB size, word only.
  input wire logic [31:0] hwdata_i, // AHB write data.
  input wire logic hready_i, // AHB bus ready.
  output logic hreadyout_o, // AHB slave ready.
  output logic hresp_o, // AHB response, always OKAY.
  output logic [31:0] hrdata_o, // AHB read data.
  input wire logic [9:0] contact_input_i, // Raw contact inputs.
  input wire logic [7:0] time_signal_i, // Loop-one time signals.
  input wire logic [7:0] time_signal_loop_two_i, // Loop-two time signals.
  output logic [2:0] alarm_relay_output_o, // Alarm relay outputs.
  output logic [4:0] switch_output_o, // Switch outputs.
  output logic [1:0] run_state_o, // Run state per loop.
  output logic [9:0] contact_status_o // Filtered contact levels.
);
  import evl_pkg::*;

  gate_cfg_type gate_cfg [6];
  tc_cfg_type tc_cfg [2];
  loop_assign_type di_loop [10];
  di_func_type di_func [10];
  logic runrst_level;
  logic [9:0] di_level;
  logic [9:0] di_rise;
  logic [26:0] src_level;
  logic [26:0] src_rise;
  logic [5:0] gate_out;
  logic [1:0] tc_active;
  logic data_phase;
  logic wr_phase;
  logic [7:0] addr_q;

  for (genvar i = 0; i < 10; i++) begin : g_di
    contact_filter #(.STABLE_CYCLES(STABLE_CYCLES)) u_filter (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .raw_i(contact_input_i[i]),
      .level_o(di_level[i]),
      .rise_o(di_rise[i])
    );
  end

  assign src_level = {di_level, time_signal_loop_two_i, time_signal_i, 1'b0};
  // Time signals are never toggle sources, so their rise lanes stay quiet.
  assign src_rise = {di_rise, 16'h0000, 1'b0};

  for (genvar g = 0; g < 6; g++) begin : g_gate
    logic in_a;
    logic in_b;
    gate_input u_in_a (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .sel_i(gate_cfg[g].src1),
      .cond_i(gate_cfg[g].cond1),
      .level_i(src_level),
      .rise_i(src_rise),
      .cond_o(in_a)
    );
    gate_input u_in_b (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .sel_i(gate_cfg[g].src2),
      .cond_i(gate_cfg[g].cond2),
      .level_i(src_level),
      .rise_i(src_rise),
      .cond_o(in_b)
    );
    always_comb begin
      unique case (gate_cfg[g].func)
        FUNC_AND: gate_out[g] = in_a & in_b;
        FUNC_OR: gate_out[g] = in_a | in_b;
        FUNC_XOR: gate_out[g] = in_a ^ in_b;
        default: gate_out[g] = 1'b0;
      endcase
    end
  end

  for (genvar t = 0; t < 2; t++) begin : g_tc
    logic lvl;
    logic lvl_q;
    logic busy;
    logic [24:0] cyc_cnt;
    logic [12:0] sec_cnt;
    logic [12:0] act_cnt;
    logic [24:0] pulse_cnt;
    logic fire;
    logic start;

    always_comb begin
      lvl = 1'b0;
      if (tc_cfg[t].src <= `EVL_SRC_LAST) begin
        lvl = src_level[tc_cfg[t].src];
      end
    end
    assign start = lvl & ~lvl_q & (tc_cfg[t].preset != 13'h0000);

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        lvl_q <= 1'b0;
        busy <= 1'b0;
        cyc_cnt <= 25'h0000000;
        sec_cnt <= 13'h0000;
      end else begin
        lvl_q <= lvl;
        if (tc_cfg[t].mode != TC_TIMER) begin
          busy <= 1'b0;
        end else if (start && !busy) begin
          busy <= 1'b1;
          cyc_cnt <= 25'h0000000;
          sec_cnt <= 13'h0000;
        end else if (busy) begin
          if (cyc_cnt == 25'(ONE_SEC_CYCLES - 1)) begin
            cyc_cnt <= 25'h0000000;
            sec_cnt <= sec_cnt + 13'h0001;
            if (sec_cnt + 13'h0001 >= tc_cfg[t].preset) begin
              busy <= 1'b0;
            end
          end else begin
            cyc_cnt <= cyc_cnt + 25'h0000001;
          end
        end
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i || tc_cfg[t].mode != TC_COUNTER) begin
        act_cnt <= 13'h0000;
      end else if (start) begin
        act_cnt <= (act_cnt + 13'h0001 >= tc_cfg[t].preset) ? 13'h0000 : act_cnt + 13'h0001;
      end
    end

    always_comb begin
      unique case (tc_cfg[t].mode)
        TC_TIMER: fire = busy && cyc_cnt == 25'(ONE_SEC_CYCLES - 1)
                         && sec_cnt + 13'h0001 >= tc_cfg[t].preset;
        TC_COUNTER: fire = start && act_cnt + 13'h0001 >= tc_cfg[t].preset;
        default: fire = 1'b0;
      endcase
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        pulse_cnt <= 25'h0000000;
      end else if (fire) begin
        pulse_cnt <= 25'(ONE_SEC_CYCLES);
      end else if (pulse_cnt != 25'h0000000) begin
        pulse_cnt <= pulse_cnt - 25'h0000001;
      end
    end
    assign tc_active[t] = pulse_cnt != 25'h0000000;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      alarm_relay_output_o <= 3'h0;
      switch_output_o <= 5'h00;
    end else begin
      for (int k = 0; k < 3; k++) begin
        alarm_relay_output_o[k] <= gate_out[k] ^ gate_cfg[k].sense;
        switch_output_o[k] <= gate_out[k + 3] ^ gate_cfg[k + 3].sense;
      end
      for (int k = 0; k < 2; k++) begin
        switch_output_o[k + 3] <= tc_active[k] ^ tc_cfg[k].sense;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      contact_status_o <= 10'h000;
    end else begin
      contact_status_o <= di_level;
    end
  end

  // Run/reset per loop; inputs also used as logic sources still take part here.
  always_ff @(posedge core_clk_i) begin
    logic [1:0] hit_lvl;
    logic [1:0] hit_rise;
    hit_lvl = 2'h0;
    hit_rise = 2'h0;
    if (rst_i) begin
      run_state_o <= 2'h0;
    end else begin
      for (int i = 0; i < 10; i++) begin
        for (int l = 0; l < 2; l++) begin
          if (di_func[i] == DI_RUN_RESET
              && (di_loop[i] == LOOP_BOTH || int'(di_loop[i]) == l)) begin
            hit_lvl[l] = hit_lvl[l] | di_level[i];
            hit_rise[l] = hit_rise[l] | di_rise[i];
          end
        end
      end
      for (int l = 0; l < 2; l++) begin
        if (runrst_level) begin
          run_state_o[l] <= hit_lvl[l];
        end else if (hit_rise[l]) begin
          run_state_o[l] <= ~run_state_o[l];
        end
      end
    end
  end

  // Reads take one wait state so that hrdata can come from a flip-flop.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      data_phase <= 1'b0;
      wr_phase <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      if (hready_i) begin
        data_phase <= hsel_i & htrans_i[1];
        wr_phase <= hsel_i & htrans_i[1] & hwrite_i;
        addr_q <= haddr_i[7:0];
        hreadyout_o <= ~(hsel_i & htrans_i[1] & ~hwrite_i);
      end else begin
        hreadyout_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (data_phase && !hreadyout_o) begin
      hrdata_o <= 32'h00000000;
      for (int k = 0; k < 6; k++) begin
        if (addr_q == 8'(`EVL_REG_GATE_BASE + 4 * k)) begin
          hrdata_o <= {15'h0000, gate_cfg[k]};
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (addr_q == 8'(`EVL_REG_TC_BASE + 4 * k)) begin
          hrdata_o <= {12'h000, tc_cfg[k]};
        end
      end
      if (addr_q == `EVL_REG_DI_LOOP) begin
        for (int i = 0; i < 10; i++) begin
          hrdata_o[i * `EVL_DI_LOOP_W +: `EVL_DI_LOOP_W] <= di_loop[i];
        end
        hrdata_o[`EVL_DI_LEVEL_BIT] <= runrst_level;
      end
      if (addr_q == `EVL_REG_DI_FUNC) begin
        for (int i = 1; i < 10; i++) begin
          hrdata_o[(i - 1) * `EVL_DI_FUNC_W +: `EVL_DI_FUNC_W] <= di_func[i];
        end
      end
      if (addr_q == `EVL_REG_STATUS) begin
        hrdata_o[9:0] <= di_level;
        hrdata_o[`EVL_STAT_RUN_LSB +: 2] <= run_state_o;
        hrdata_o[`EVL_STAT_OUT_LSB +: 8] <= {switch_output_o, alarm_relay_output_o};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    logic [31:0] w;
    cond_type c1;
    cond_type c2;
    w = hwdata_i;
    c1 = cond_type'(w[`EVL_GATE_COND1_LSB +: 2]);
    c2 = cond_type'(w[`EVL_GATE_COND2_LSB +: 2]);
    for (int k = 0; k < 6; k++) begin
      if (rst_i) begin
        gate_cfg[k] <= gate_cfg_type'(`EVL_GATE_RESET);
      end else if (wr_phase && addr_q == 8'(`EVL_REG_GATE_BASE + 4 * k)) begin
        if (w[`EVL_GATE_FUNC_LSB +: 2] != 2'h3) begin
          gate_cfg[k].func <= logic_func_type'(w[`EVL_GATE_FUNC_LSB +: 2]);
        end
        gate_cfg[k].src1 <= w[`EVL_GATE_SRC1_LSB +: 5];
        gate_cfg[k].src2 <= w[`EVL_GATE_SRC2_LSB +: 5];
        gate_cfg[k].cond1 <= (c1 == COND_TOGGLE && w[`EVL_GATE_SRC1_LSB +: 5] >=
          `EVL_SRC_TS1_FIRST && w[`EVL_GATE_SRC1_LSB +: 5] <= `EVL_SRC_TS2_LAST)
          || w[`EVL_GATE_COND1_LSB +: 2] == 2'h3 ? COND_PASS : c1;
        gate_cfg[k].cond2 <= (c2 == COND_TOGGLE && w[`EVL_GATE_SRC2_LSB +: 5] >=
          `EVL_SRC_TS1_FIRST && w[`EVL_GATE_SRC2_LSB +: 5] <= `EVL_SRC_TS2_LAST)
          || w[`EVL_GATE_COND2_LSB +: 2] == 2'h3 ? COND_PASS : c2;
        gate_cfg[k].sense <= w[`EVL_GATE_SENSE_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (rst_i) begin
        tc_cfg[k] <= tc_cfg_type'(`EVL_TC_RESET);
      end else if (wr_phase && addr_q == 8'(`EVL_REG_TC_BASE + 4 * k)) begin
        if (hwdata_i[`EVL_TC_PRESET_LSB +: 13] <= `EVL_PRESET_MAX) begin
          tc_cfg[k].preset <= hwdata_i[`EVL_TC_PRESET_LSB +: 13];
        end
        tc_cfg[k].src <= hwdata_i[`EVL_TC_SRC_LSB +: 5];
        tc_cfg[k].mode <= tc_mode_type'(hwdata_i[`EVL_TC_MODE_BIT]);
        tc_cfg[k].sense <= hwdata_i[`EVL_TC_SENSE_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    logic [2:0] f;
    f = 3'h0;
    if (rst_i) begin
      runrst_level <= 1'b0;
      for (int i = 0; i < 10; i++) begin
        di_loop[i] <= loop_assign_type'(`EVL_DI_LOOP_RESET);
        di_func[i] <= i == 0 ? DI_RUN_RESET : DI_NONE;
      end
    end else if (wr_phase && addr_q == `EVL_REG_DI_LOOP) begin
      runrst_level <= hwdata_i[`EVL_DI_LEVEL_BIT];
      for (int i = 1; i < 10; i++) begin
        if (hwdata_i[i * `EVL_DI_LOOP_W +: `EVL_DI_LOOP_W] != 2'h3) begin
          di_loop[i] <= loop_assign_type'(hwdata_i[i * `EVL_DI_LOOP_W +: `EVL_DI_LOOP_W]);
        end
      end
    end else if (wr_phase && addr_q == `EVL_REG_DI_FUNC) begin
      for (int i = 1; i < 10; i++) begin
        f = hwdata_i[(i - 1) * `EVL_DI_FUNC_W +: `EVL_DI_FUNC_W];
        if (f <= 3'(DI_OTHER) || ((f == 3'(DI_PAT_TWO) || f == 3'(DI_PAT_THREE))
            && (i == 4 || i == 7)) || ((f == 3'(DI_PAT_FOUR) || f == 3'(DI_PAT_FIVE))
            && i == 4)) begin
          di_func[i] <= di_func_type'(f);
        end
      end
    end
  end
endmodule // event_logic_timer_counter

// File: evl_sva.sv
module evl_sva #(
  parameter int unsigned ONE_SEC_CYCLES = 20
) (
  input wire logic core_clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic hsel_i, // Select.
  input wire logic [1:0] htrans_i, // Transfer type.
  input wire logic hwrite_i, // Write flag.
  input wire logic hready_i, // Bus ready.
  input wire logic hreadyout_o, // Slave ready.
  input wire logic hresp_o, // Response.
  input wire logic [31:0] hrdata_o, // Read data.
  input wire logic [9:0] contact_input_i, // Raw contacts.
  input wire logic [2:0] alarm_relay_output_o, // Alarm outputs.
  input wire logic [4:0] switch_output_o, // Switch outputs.
  input wire logic [1:0] run_state_o, // Run state.
  input wire logic [9:0] contact_status_o // Filtered contacts.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic rd_take;
  logic wr_take;
  logic [31:0] hi_cnt;
  assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign wr_take = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  // The counter gives the length of each high stretch on the pulse output.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !switch_output_o[3]) hi_cnt <= 32'h0;
    else hi_cnt <= hi_cnt + 32'h1;
  end
  property p_okay;
    hresp_o == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rd_wait;
    rd_take |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_zero;
    wr_take |=> hreadyout_o;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
  property p_rd_hold;
    hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_filter;
    ((contact_status_o ^ $past(contact_status_o)) &
     (contact_status_o ^ $past(contact_input_i, 4))) == 10'h000;
  endproperty
  a_filter: assert property (p_filter) else $error("status not filtered");
  property p_pulse;
    $fell(switch_output_o[3]) |-> hi_cnt >= ONE_SEC_CYCLES;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too short");
  property p_pulse_min;
    $rose(switch_output_o[4]) |-> switch_output_o[4] [*8];
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("count pulse short");
  property p_run_edge;
    $rose(contact_status_o[0]) |-> ##[0:2] $changed(run_state_o[0]);
  endproperty
  a_run_edge: assert property (p_run_edge) else $error("run did not switch");
  property p_reset_val;
    $fell(rst_i) |-> hreadyout_o && hrdata_o == 32'h0 && run_state_o == 2'h0 &&
      contact_status_o == 10'h000 && switch_output_o == 5'h00 && alarm_relay_output_o == 3'h0;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset value wrong");
  c_read: cover property (rd_take ##1 !hreadyout_o);
  c_pulse: cover property ($fell(switch_output_o[3]));
  c_run: cover property ($changed(run_state_o));
endmodule // evl_sva

bind event_logic_timer_counter evl_sva #(.ONE_SEC_CYCLES(ONE_SEC_CYCLES)) evl_sva_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .hrdata_o(hrdata_o), .contact_input_i(contact_input_i),
  .alarm_relay_output_o(alarm_relay_output_o), .switch_output_o(switch_output_o),
  .run_state_o(run_state_o), .contact_status_o(contact_status_o));

// File: contact_model.sv
module contact_model #(
  parameter int HOLD = 12
) (
  input wire logic core_clk_i, // System clock.
  output logic [9:0] contact_o, // Dry contact levels.
  output logic [7:0] ts_one_o, // Loop-one time signals.
  output logic [7:0] ts_two_o // Loop-two time signals.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    contact_o = 10'h000;
    ts_one_o = 8'h00;
    ts_two_o = 8'h00;
  end
  // minimum level hold.
  // Holding past the filter time keeps every change countable.
  task press(input int b, input logic v);
    @(posedge core_clk_i);
    contact_o[b] <= v;
    repeat (HOLD) @(posedge core_clk_i);
  endtask
  task tsig(input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk_i);
    ts_one_o <= a;
    ts_two_o <= b;
    repeat (3) @(posedge core_clk_i);
  endtask
endmodule // contact_model

// File: tb_event_logic_timer_counter.sv
module tb_event_logic_timer_counter;
  timeunit 1ns;
  timeprecision 1ns;
  import evl_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic hreadyout_o, hresp_o;
  logic [31:0] hrdata_o, rd;
  logic [9:0] contact_input_i, contact_status_o;
  logic [7:0] time_signal_i, time_signal_loop_two_i;
  logic [2:0] alarm_relay_output_o;
  logic [4:0] switch_output_o;
  logic [1:0] run_state_o;
  int n_mismatch = 0;
  int tests_run = 0;
  always #25 core_clk_i = ~core_clk_i;
  event_logic_timer_counter #(.ONE_SEC_CYCLES(20), .STABLE_CYCLES(4))
    event_logic_timer_counter_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .contact_input_i(contact_input_i), .time_signal_i(time_signal_i),
    .time_signal_loop_two_i(time_signal_loop_two_i),
    .alarm_relay_output_o(alarm_relay_output_o), .switch_output_o(switch_output_o),
    .run_state_o(run_state_o), .contact_status_o(contact_status_o));
  contact_model contact_model_inst (.core_clk_i(core_clk_i), .contact_o(contact_input_i),
    .ts_one_o(time_signal_i), .ts_two_o(time_signal_loop_two_i));
  task summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wait_rdy();
    int n;
    n = 0;
    @(posedge core_clk_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        $display("[ERR] hreadyout expected 1 seen %b", hreadyout_o);
        summarize();
      end
      @(posedge core_clk_i);
    end
  endtask
  // The address phase is held until ready is seen, then data stands until ready again.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy();
    rd = hrdata_o;
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  function automatic logic [31:0] g(input logic [1:0] f, input logic [4:0] s1,
                                    input logic [4:0] s2, input logic [1:0] c1,
                                    input logic [1:0] c2, input logic sn);
    return {15'h0, sn, c2, c1, s2, s1, f};
  endfunction
  task t_reset();
    rdchk("gate_cfg", 8'h00, 32'h0);
    rdchk("tc_cfg", 8'h18, 32'h0);
    rdchk("loop_cfg", 8'h20, 32'h0);
    xfer(1'b1, 8'h2C, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h2C, 32'h0);
    $display("test reset done");
  endtask
  task t_gates();
    logic e;
    for (int f = 0; f < 3; f++) begin
      xfer(1'b1, 8'h00, g(f[1:0], 5'h12, 5'h13, 2'h0, 2'h0, 1'b0));
      for (int k = 0; k < 4; k++) begin
        contact_model_inst.press(1, k[0]);
        contact_model_inst.press(2, k[1]);
        e = (f == 0) ? (k[0] & k[1]) : (f == 1) ? (k[0] | k[1]) : (k[0] ^ k[1]);
        chk("alarm0", 32'(e), 32'(alarm_relay_output_o[0]));
        chk("status", {29'h0, k[1:0], 1'b0}, 32'(contact_status_o));
      end
    end
    xfer(1'b1, 8'h00, g(2'h0, 5'h12, 5'h13, 2'h1, 2'h0, 1'b1));
    contact_model_inst.press(1, 1'b0);
    chk("neg_sense", 32'h0, 32'(alarm_relay_output_o[0]));
    contact_model_inst.press(1, 1'b1);
    chk("neg_sense", 32'h1, 32'(alarm_relay_output_o[0]));
    $display("test gates done");
  endtask
  task t_toggle();
    logic a;
    xfer(1'b1, 8'h00, g(2'h1, 5'h12, 5'h00, 2'h2, 2'h0, 1'b0));
    contact_model_inst.press(1, 1'b0);
    contact_model_inst.press(1, 1'b1);
    a = alarm_relay_output_o[0];
    contact_model_inst.press(1, 1'b0);
    chk("latch_hold", 32'(a), 32'(alarm_relay_output_o[0]));
    contact_model_inst.press(1, 1'b1);
    chk("latch_flip", 32'(!a), 32'(alarm_relay_output_o[0]));
    xfer(1'b1, 8'h00, g(2'h3, 5'h01, 5'h00, 2'h2, 2'h0, 1'b0));
    rdchk("ts_no_latch", 8'h00, g(2'h1, 5'h01, 5'h00, 2'h0, 2'h0, 1'b0));
    $display("test toggle done");
  endtask
  task t_src();
    xfer(1'b1, 8'h0C, g(2'h1, 5'h01, 5'h09, 2'h0, 2'h0, 1'b0));
    xfer(1'b1, 8'h04, g(2'h1, 5'h00, 5'h00, 2'h0, 2'h0, 1'b0));
    contact_model_inst.tsig(8'h01, 8'h00);
    chk("sw_gate", 32'h1, 32'(switch_output_o[0]));
    contact_model_inst.tsig(8'h00, 8'h01);
    chk("sw_gate", 32'h1, 32'(switch_output_o[0]));
    contact_model_inst.tsig(8'h00, 8'h00);
    chk("sw_gate", 32'h0, 32'(switch_output_o[0]));
    contact_model_inst.press(3, 1'b1);
    chk("src_none", 32'h0, 32'(alarm_relay_output_o[1]));
    contact_model_inst.press(3, 1'b0);
    $display("test sources done");
  endtask
  task t_timer();
    xfer(1'b1, 8'h18, {12'h0, 1'b0, 1'b0, 5'h14, 13'h0002});
    xfer(1'b1, 8'h18, {12'h0, 1'b0, 1'b0, 5'h14, 13'h1389});
    rdchk("preset_max", 8'h18, {12'h0, 1'b0, 1'b0, 5'h14, 13'h0002});
    contact_model_inst.press(3, 1'b1);
    repeat (30) @(posedge core_clk_i);
    chk("timer_wait", 32'h0, 32'(switch_output_o[3]));
    repeat (15) @(posedge core_clk_i);
    chk("timer_fire", 32'h1, 32'(switch_output_o[3]));
    repeat (20) @(posedge core_clk_i);
    chk("timer_end", 32'h0, 32'(switch_output_o[3]));
    contact_model_inst.press(3, 1'b0);
    $display("test timer done");
  endtask
  task t_counter();
    xfer(1'b1, 8'h1C, {12'h0, 1'b0, 1'b1, 5'h15, 13'h0003});
    for (int i = 0; i < 3; i++) begin
      contact_model_inst.press(4, 1'b1);
      chk("count_fire", 32'(i == 2), 32'(switch_output_o[4]));
      contact_model_inst.press(4, 1'b0);
    end
    $display("test counter done");
  endtask
  task t_run();
    logic [1:0] ex [4] = '{2'h1, 2'h1, 2'h0, 2'h0};
    for (int i = 0; i < 4; i++) begin
      contact_model_inst.press(0, ~i[0]);
      chk("run_edge", 32'(ex[i]), 32'(run_state_o));
    end
    xfer(1'b1, 8'h20, 32'h00100008);
    xfer(1'b1, 8'h24, 32'h00000001);
    rdchk("loop_cfg", 8'h20, 32'h00100008);
    contact_model_inst.press(1, 1'b0);
    contact_model_inst.press(1, 1'b1);
    chk("run_level", 32'h3, 32'(run_state_o));
    contact_model_inst.press(1, 1'b0);
    chk("run_level", 32'h0, 32'(run_state_o));
    xfer(1'b1, 8'h24, 32'h00000019);
    rdchk("pat_place", 8'h24, 32'h00000001);
    xfer(1'b1, 8'h24, 32'h00140601);
    rdchk("pat_place", 8'h24, 32'h00000601);
    xfer(1'b1, 8'h08, g(2'h0, 5'h00, 5'h00, 2'h0, 2'h0, 1'b1));
    xfer(1'b1, 8'h14, g(2'h0, 5'h00, 5'h00, 2'h0, 2'h0, 1'b1));
    rdchk("status", 8'h28, 32'h00024004);
    chk("outputs", 32'h24, {24'h0, switch_output_o, alarm_relay_output_o});
    $display("test run done");
  endtask
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_gates();
    t_toggle();
    t_src();
    t_timer();
    t_counter();
    t_run();
    summarize();
  end
endmodule // tb_event_logic_timer_counter
